/* File: verilog/uart_shadow_pkg.sv */
// package: register map, field positions and reset values of the uart shadow and status registers
`default_nettype none

package uart_shadow_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] OFS_FIFO_STATUS   = 32'h5000107c;
  localparam logic [31:0] OFS_TX_FILL_LEVEL = 32'h50001080;
  localparam logic [31:0] OFS_RX_FILL_LEVEL = 32'h50001084;
  localparam logic [31:0] OFS_SW_RESET_CTRL = 32'h50001088;
  localparam logic [31:0] OFS_RTS_SHADOW    = 32'h5000108c;
  localparam logic [31:0] OFS_BREAK_SHADOW  = 32'h50001090;
  localparam logic [31:0] OFS_IRQ_STATUS    = 32'h500010c0;
  localparam logic [31:0] OFS_IRQ_MASK      = 32'h500010c4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_TX_NOT_FULL     = 1;
  localparam int BIT_TX_QUEUE_RESET  = 2;
  localparam int BIT_RX_QUEUE_RESET  = 1;
  localparam int BIT_WHOLE_CTRL_RST  = 0;
  localparam int BIT_RTS_SHADOW      = 0;
  localparam int BIT_BREAK_SHADOW    = 0;
  localparam int LEVEL_WIDTH         = 16;
  localparam int REG_WIDTH           = 16;

  // interrupt status / mask layout
  localparam int IRQ_BITS            = 3;
  localparam int IRQ_TX_FULL         = 0;
  localparam int IRQ_RX_FULL         = 1;
  localparam int IRQ_TX_OVERFLOW     = 2;

  // ----------------------------------------------------------------
  // reset values and defaults
  // ----------------------------------------------------------------
  localparam logic             RST_TX_NOT_FULL = 1'b1;
  localparam logic             RST_RTS_SHADOW  = 1'b0;
  localparam logic             RST_BREAK       = 1'b0;
  localparam logic [2:0]       RST_IRQ_MASK    = 3'h0;
  localparam int               FIFO_DEPTH_DEF  = 16;
  localparam int               QUEUE_TX        = 0;
  localparam int               QUEUE_RX        = 1;

endpackage : uart_shadow_pkg

`default_nettype wire

/* File: verilog/uart_shadow_status_regs.sv */
// module: uart fifo status, fill levels, software reset and rts/break shadow registers on avalon-mm
//
// Functional notes
// - transmit-not-full reads 1 while the transmit queue has room, 0 when full.
// - transmit level field, 16 bits, read-only, equals entries held, resets to zero.
// - receive level field, 16 bits, read-only, equals entries held, resets to zero.
// - writing 1 to reset bit 2 empties the transmit queue; self-clearing.
// - writing 1 to reset bit 1 empties the receive queue; self-clearing.
// - reset bit 0 resets whole controller, asserted asynchronously, released synchronously, both domains.
// - rts shadow bit is the same storage as the modem control rts bit.
// - outside loopback and without automatic flow control, rts output is low exactly when rts bit is one.
// - with flow control and queues on, rts output forced high above receive trigger.
// - in loopback rts output stays high and rts value loops to modem status input.
// - break shadow shares storage with line control break bit; forces spacing state.
// - outside loopback, break holds serial output low until software clears it.
// - outside loopback, in infrared mode with break set, infrared output pulses continuously.
// - in loopback, break is fed to own receiver, not to serial output.
// - queue depth is configurable, sixteen by default; levels count up to depth.
`timescale 1ns/10ps
`default_nettype none

module uart_shadow_status_regs
  import uart_shadow_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // avalon-mm slave
  input  wire logic [31:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // queue push/pop strobes from the data path
  input  wire logic        i_tx_push,
  input  wire logic        i_tx_pop,
  input  wire logic        i_rx_push,
  input  wire logic        i_rx_pop,
  // main modem / line control access to the shared bits
  input  wire logic        i_modem_rts_wr,
  input  wire logic        i_modem_rts_wdata,
  input  wire logic        i_line_break_wr,
  input  wire logic        i_line_break_wdata,
  // mode bits held by the main control registers
  input  wire logic        i_auto_flow_en,
  input  wire logic        i_queue_en,
  input  wire logic        i_loopback_en,
  input  wire logic        i_ir_mode_en,
  input  wire logic        i_rx_above_trigger,
  // serial data from the transmitter
  input  wire logic        i_tx_serial,
  input  wire logic        i_ir_serial_b,
  // line side
  output logic             o_rts_b,
  output logic             o_sout,
  output logic             o_ir_out_b,
  output logic             o_loop_cts,
  output logic             o_loop_rx,
  // shared bit values and resets towards the rest of the controller
  output logic             o_rts_ctrl,
  output logic             o_break_ctrl,
  output logic             o_tx_empty_now,
  output logic             o_rx_empty_now,
  output logic             o_ctrl_rst_b,
  output logic             o_irq
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  logic              ack_reg;
  logic              req;
  logic              wr_take;
  logic              lane0;
  logic              sw_reset_wr;
  logic              whole_rst_req_reg;
  logic              ctrl_rst_async_b;
  logic [1:0]        rst_sync_reg;
  logic              int_rst_b;
  logic              rts_reg;
  logic              break_reg;
  logic [CW-1:0]     count_reg [2];
  logic [1:0]        queue_reset;
  logic [1:0]        push;
  logic [1:0]        pop;
  logic              tx_not_full;
  logic [IRQ_BITS-1:0] irq_status_reg;
  logic [IRQ_BITS-1:0] irq_mask_reg;
  logic [IRQ_BITS-1:0] irq_event;
  logic              ir_pulse_reg;
  logic [31:0]       rdata_next;

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, write commits and read data stands
  // at the edge where waitrequest is low
  // ----------------------------------------------------------------
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_reg;
  assign wr_take           = i_avs_write & ack_reg;
  assign lane0             = i_avs_byteenable[0];

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // ----------------------------------------------------------------
  // software reset register
  // ----------------------------------------------------------------
  assign sw_reset_wr = wr_take & lane0 & reg_hit(i_avs_address, OFS_SW_RESET_CTRL);
  assign queue_reset[QUEUE_TX] = sw_reset_wr & i_avs_writedata[BIT_TX_QUEUE_RESET];
  assign queue_reset[QUEUE_RX] = sw_reset_wr & i_avs_writedata[BIT_RX_QUEUE_RESET];

  // request lives one cycle; the sync pair below turns it into an
  // asynchronously asserted, synchronously released controller reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      whole_rst_req_reg <= 1'b0;
    end else begin
      whole_rst_req_reg <= sw_reset_wr & i_avs_writedata[BIT_WHOLE_CTRL_RST];
    end
  end

  assign ctrl_rst_async_b = ~whole_rst_req_reg;

  always_ff @(posedge i_clk or negedge ctrl_rst_async_b) begin
    if (!ctrl_rst_async_b) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // serial logic runs on this clock too, so one reset covers both domains
  assign o_ctrl_rst_b = rst_sync_reg[1];
  assign int_rst_b    = i_rst_b & rst_sync_reg[1];

  // ----------------------------------------------------------------
  // queue control: occupancy counters, one per direction
  // ----------------------------------------------------------------
  assign push = {i_rx_push, i_tx_push};
  assign pop  = {i_rx_pop, i_tx_pop};

  for (genvar q = 0; q < 2; q++) begin : g_queue
    logic do_push;
    logic do_pop;
    // push on full and pop on empty are lost, as the queue drops them
    assign do_push = push[q] & (count_reg[q] != DEPTH_C);
    assign do_pop  = pop[q] & (count_reg[q] != '0);
    always_ff @(posedge i_clk) begin
      if (!int_rst_b || queue_reset[q]) begin
        count_reg[q] <= '0;
      end else if (do_push && !do_pop) begin
        count_reg[q] <= count_reg[q] + CW'(1);
      end else if (do_pop && !do_push) begin
        count_reg[q] <= count_reg[q] - CW'(1);
      end
    end
  end

  assign tx_not_full    = (count_reg[QUEUE_TX] != DEPTH_C);
  assign o_tx_empty_now = queue_reset[QUEUE_TX];
  assign o_rx_empty_now = queue_reset[QUEUE_RX];

  // ----------------------------------------------------------------
  // shared rts and break storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!int_rst_b) begin
      rts_reg <= RST_RTS_SHADOW;
    end else if (wr_take && lane0 && reg_hit(i_avs_address, OFS_RTS_SHADOW)) begin
      rts_reg <= i_avs_writedata[BIT_RTS_SHADOW];
    end else if (i_modem_rts_wr) begin
      rts_reg <= i_modem_rts_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!int_rst_b) begin
      break_reg <= RST_BREAK;
    end else if (wr_take && lane0 && reg_hit(i_avs_address, OFS_BREAK_SHADOW)) begin
      break_reg <= i_avs_writedata[BIT_BREAK_SHADOW];
    end else if (i_line_break_wr) begin
      break_reg <= i_line_break_wdata;
    end
  end

  assign o_rts_ctrl   = rts_reg;
  assign o_break_ctrl = break_reg;

  // ----------------------------------------------------------------
  // line outputs, registered
  // ----------------------------------------------------------------
  // rts high tells the partner to pause, low that we can exchange data
  always_ff @(posedge i_clk) begin
    if (!int_rst_b) begin
      o_rts_b    <= 1'b1;
      o_loop_cts <= 1'b0;
    end else if (i_loopback_en) begin
      o_rts_b    <= 1'b1;
      o_loop_cts <= rts_reg;
    end else begin
      o_rts_b    <= ~rts_reg | (i_auto_flow_en & i_queue_en & i_rx_above_trigger);
      o_loop_cts <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!int_rst_b) begin
      o_sout    <= 1'b1;
      o_loop_rx <= 1'b1;
    end else if (i_loopback_en) begin
      o_sout    <= 1'b1;
      o_loop_rx <= i_tx_serial & ~break_reg;
    end else begin
      o_sout    <= i_tx_serial & ~break_reg;
      o_loop_rx <= 1'b1;
    end
  end

  // break in infrared mode toggles every clock: a static level would not
  // be seen by an infrared receiver
  always_ff @(posedge i_clk) begin
    if (!int_rst_b) begin
      ir_pulse_reg <= 1'b1;
      o_ir_out_b   <= 1'b1;
    end else if (i_ir_mode_en && break_reg && !i_loopback_en) begin
      ir_pulse_reg <= ~ir_pulse_reg;
      o_ir_out_b   <= ir_pulse_reg;
    end else begin
      ir_pulse_reg <= 1'b1;
      o_ir_out_b   <= i_loopback_en ? 1'b1 : i_ir_serial_b;
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins over clear
  // ----------------------------------------------------------------
  assign irq_event[IRQ_TX_FULL]     = i_tx_push & ~i_tx_pop & (count_reg[QUEUE_TX] == DEPTH_C - CW'(1));
  assign irq_event[IRQ_RX_FULL]     = i_rx_push & ~i_rx_pop & (count_reg[QUEUE_RX] == DEPTH_C - CW'(1));
  assign irq_event[IRQ_TX_OVERFLOW] = i_tx_push & ~i_tx_pop & ~tx_not_full;

  always_ff @(posedge i_clk) begin
    if (!int_rst_b) begin
      irq_status_reg <= '0;
    end else if (wr_take && lane0 && reg_hit(i_avs_address, OFS_IRQ_STATUS)) begin
      irq_status_reg <= (irq_status_reg & ~i_avs_writedata[IRQ_BITS-1:0]) | irq_event;
    end else begin
      irq_status_reg <= irq_status_reg | irq_event;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!int_rst_b) begin
      irq_mask_reg <= RST_IRQ_MASK;
    end else if (wr_take && lane0 && reg_hit(i_avs_address, OFS_IRQ_MASK)) begin
      irq_mask_reg <= i_avs_writedata[IRQ_BITS-1:0];
    end
  end

  assign o_irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // read mux, captured in the wait cycle
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    if (reg_hit(i_avs_address, OFS_FIFO_STATUS)) begin
      rdata_next[BIT_TX_NOT_FULL] = tx_not_full;
    end else if (reg_hit(i_avs_address, OFS_TX_FILL_LEVEL)) begin
      rdata_next[LEVEL_WIDTH-1:0] = LEVEL_WIDTH'(count_reg[QUEUE_TX]);
    end else if (reg_hit(i_avs_address, OFS_RX_FILL_LEVEL)) begin
      rdata_next[LEVEL_WIDTH-1:0] = LEVEL_WIDTH'(count_reg[QUEUE_RX]);
    end else if (reg_hit(i_avs_address, OFS_RTS_SHADOW)) begin
      rdata_next[BIT_RTS_SHADOW] = rts_reg;
    end else if (reg_hit(i_avs_address, OFS_BREAK_SHADOW)) begin
      rdata_next[BIT_BREAK_SHADOW] = break_reg;
    end else if (reg_hit(i_avs_address, OFS_IRQ_STATUS)) begin
      rdata_next[IRQ_BITS-1:0] = irq_status_reg;
    end else if (reg_hit(i_avs_address, OFS_IRQ_MASK)) begin
      rdata_next[IRQ_BITS-1:0] = irq_mask_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_avs_readdata <= '0;
    end else if (i_avs_read && !ack_reg) begin
      o_avs_readdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_sw_reset_write(int b);
    wr_take && lane0 && reg_hit(i_avs_address, OFS_SW_RESET_CTRL) && i_avs_writedata[b];
  endsequence

  sequence s_read_start(logic [31:0] ofs);
    i_avs_read && !ack_reg && reg_hit(i_avs_address, ofs);
  endsequence

  AST_TX_FULL_FLAG: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_read_start(OFS_FIFO_STATUS) |=> o_avs_readdata[BIT_TX_NOT_FULL] == ($past(count_reg[QUEUE_TX]) != DEPTH_C))
    else $error("tx not full flag disagrees with queue occupancy");

  AST_TX_LEVEL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_read_start(OFS_TX_FILL_LEVEL) |=> o_avs_readdata[CW-1:0] == $past(count_reg[QUEUE_TX]))
    else $error("tx level read does not match occupancy");

  AST_RX_LEVEL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_read_start(OFS_RX_FILL_LEVEL) |=> o_avs_readdata[CW-1:0] == $past(count_reg[QUEUE_RX]))
    else $error("rx level read does not match occupancy");

  AST_TX_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_sw_reset_write(BIT_TX_QUEUE_RESET) |=> count_reg[QUEUE_TX] == '0)
    else $error("tx queue not emptied by reset bit");

  AST_RX_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_sw_reset_write(BIT_RX_QUEUE_RESET) |=> count_reg[QUEUE_RX] == '0)
    else $error("rx queue not emptied by reset bit");

  AST_CTRL_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_sw_reset_write(BIT_WHOLE_CTRL_RST) |=> !o_ctrl_rst_b [*3] ##1 o_ctrl_rst_b)
    else $error("controller reset pulse has wrong shape");

  AST_RTS_DIRECT: assert property (@(posedge i_clk) disable iff (!int_rst_b)
    (!i_auto_flow_en && !i_loopback_en) |=> o_rts_b == !$past(rts_reg))
    else $error("rts output does not follow rts bit");

  AST_RTS_GATED: assert property (@(posedge i_clk) disable iff (!int_rst_b)
    (i_auto_flow_en && i_queue_en && i_rx_above_trigger && !i_loopback_en) |=> o_rts_b)
    else $error("rts not forced high above trigger");

  AST_RTS_LOOP: assert property (@(posedge i_clk) disable iff (!int_rst_b)
    i_loopback_en |=> o_rts_b && (o_loop_cts == $past(rts_reg)))
    else $error("loopback rts handling wrong");

  AST_BREAK_LOW: assert property (@(posedge i_clk) disable iff (!int_rst_b)
    (break_reg && !i_loopback_en) |=> !o_sout)
    else $error("serial output not held low during break");

  AST_IR_PULSE: assert property (@(posedge i_clk) disable iff (!int_rst_b)
    (i_ir_mode_en && break_reg && !i_loopback_en) [*3] |-> o_ir_out_b != $past(o_ir_out_b))
    else $error("infrared output not pulsing during break");

  AST_BREAK_LOOP: assert property (@(posedge i_clk) disable iff (!int_rst_b)
    (break_reg && i_loopback_en) |=> o_sout && !o_loop_rx)
    else $error("loopback break not routed to receiver");

  AST_SW_RESET_READ_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_read_start(OFS_SW_RESET_CTRL) |=> o_avs_readdata == '0)
    else $error("software reset register read nonzero");

endmodule : uart_shadow_status_regs

`default_nettype wire

/* File: tb/uart_line_partner.sv */
// remote modem model: follows request-to-send and watches the serial line for a break
`timescale 1ns/10ps
`default_nettype none

module uart_line_partner (
  // clock
  input  wire logic i_clk,
  // line from the controller
  input  wire logic i_rts_b,
  input  wire logic i_sout,
  // what the remote side concludes
  output logic      o_may_send,
  output logic      o_break_seen
);
  logic [3:0] low_cnt_reg;

  // high means pause, low means ready to exchange data
  assign o_may_send = ~i_rts_b;

  // a spacing level longer than any frame is taken as a break
  always_ff @(posedge i_clk) begin
    if (i_sout) begin
      low_cnt_reg <= 4'h0;
    end else if (low_cnt_reg != 4'hf) begin
      low_cnt_reg <= low_cnt_reg + 4'h1;
    end
  end

  assign o_break_seen = (low_cnt_reg == 4'hf);
endmodule : uart_line_partner

`default_nettype wire

/* File: tb/test_uart_shadow_status_regs.sv */
// self-checking testbench of the uart shadow and status registers
`timescale 1ns/10ps
`default_nettype none

module test_uart_shadow_status_regs;
  import uart_shadow_pkg::*;
  localparam int DEPTH = 4;
  logic i_clk, i_rst_b, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [31:0] i_avs_address, i_avs_writedata, o_avs_readdata, wd;
  logic [3:0]  i_avs_byteenable;
  logic i_tx_push, i_tx_pop, i_rx_push, i_rx_pop, i_modem_rts_wr, i_modem_rts_wdata, i_line_break_wr;
  logic i_line_break_wdata, i_auto_flow_en, i_queue_en, i_loopback_en, i_ir_mode_en, i_rx_above_trigger;
  logic i_tx_serial, i_ir_serial_b, o_rts_b, o_sout, o_ir_out_b, o_loop_cts, o_loop_rx;
  logic o_rts_ctrl, o_break_ctrl, o_ctrl_rst_b, o_irq, may_send, break_seen, ir_prev, saw_low;
  logic tx_empty_now, rx_empty_now;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  string       nm_q[$];
  int          num_errors, num_checks, seed, n;

  uart_shadow_status_regs #(.FIFO_DEPTH(DEPTH)) i_uart_shadow_status_regs (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_tx_push(i_tx_push),
    .i_tx_pop(i_tx_pop), .i_rx_push(i_rx_push), .i_rx_pop(i_rx_pop), .i_modem_rts_wr(i_modem_rts_wr),
    .i_modem_rts_wdata(i_modem_rts_wdata), .i_line_break_wr(i_line_break_wr),
    .i_line_break_wdata(i_line_break_wdata),
    .i_auto_flow_en(i_auto_flow_en), .i_queue_en(i_queue_en), .i_loopback_en(i_loopback_en),
    .i_ir_mode_en(i_ir_mode_en), .i_rx_above_trigger(i_rx_above_trigger), .i_tx_serial(i_tx_serial),
    .i_ir_serial_b(i_ir_serial_b), .o_rts_b(o_rts_b), .o_sout(o_sout), .o_ir_out_b(o_ir_out_b),
    .o_loop_cts(o_loop_cts), .o_loop_rx(o_loop_rx), .o_rts_ctrl(o_rts_ctrl), .o_break_ctrl(o_break_ctrl),
    .o_tx_empty_now(tx_empty_now), .o_rx_empty_now(rx_empty_now), .o_ctrl_rst_b(o_ctrl_rst_b), .o_irq(o_irq));

  uart_line_partner i_uart_line_partner (
    .i_clk(i_clk), .i_rts_b(o_rts_b), .i_sout(o_sout), .o_may_send(may_send), .o_break_seen(break_seen));

  // ----------------------------------------------------------------
  // clock, comparison and bus tasks
  // ----------------------------------------------------------------
  always #50 i_clk = ~i_clk;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask : cyc

  // holds the request until waitrequest is sampled low, then releases it
  task automatic bus(input logic wr, input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] be);
    int t;
    t = 0;
    i_avs_address    <= adr;
    i_avs_writedata  <= dat;
    i_avs_byteenable <= be;
    i_avs_read       <= ~wr;
    i_avs_write      <= wr;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0 && t < 50) begin
      @(posedge i_clk);
      t++;
    end
    if (t == 50) chk("waitrequest", 32'h0, 32'h1);
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
    // one idle edge, so a following request is not raised in the step that drops this one
    @(posedge i_clk);
  endtask : bus

  task automatic rd(input logic [31:0] adr, input logic [31:0] exp, input logic [31:0] msk, input string nm);
    exp_q.push_back(exp);
    msk_q.push_back(msk);
    nm_q.push_back(nm);
    bus(1'b0, adr, 32'h0, 4'hf);
  endtask : rd

  task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat, 4'hf);
  endtask : wr

  task automatic strobe(input int k, input logic tx, input logic rx, input logic pop);
    repeat (k) begin
      i_tx_push <= tx & ~pop;
      i_tx_pop  <= tx & pop;
      i_rx_push <= rx;
      @(posedge i_clk);
    end
    {i_tx_push, i_tx_pop, i_rx_push} <= 3'h0;
  endtask : strobe

  // read data is taken at the edge where waitrequest is seen low
  always @(posedge i_clk) begin
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk(nm_q.pop_front(), exp_q.pop_front(), o_avs_readdata & msk_q.pop_front());
    end
  end

  // queue reset pulses stand only at the edge where the reset write is accepted
  always @(posedge i_clk) begin
    if (i_avs_write === 1'b1 && o_avs_waitrequest === 1'b0 && i_avs_address === OFS_SW_RESET_CTRL) begin
      chk("tx empty pulse", {31'h0, i_avs_writedata[2] & i_avs_byteenable[0]}, {31'h0, tx_empty_now});
      chk("rx empty pulse", {31'h0, i_avs_writedata[1] & i_avs_byteenable[0]}, {31'h0, rx_empty_now});
    end
  end

  task automatic end_of_test;
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #4000000;
    num_errors++;
    end_of_test;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_clk, i_rst_b, i_avs_read, i_avs_write, i_tx_push, i_tx_pop, i_rx_push, i_rx_pop} = 8'h0;
    {i_modem_rts_wr, i_modem_rts_wdata, i_line_break_wr, i_line_break_wdata, i_auto_flow_en} = 5'h0;
    {i_queue_en, i_loopback_en, i_ir_mode_en, i_rx_above_trigger} = 4'h0;
    {i_tx_serial, i_ir_serial_b, i_avs_byteenable} = 6'h3f;
    {i_avs_address, i_avs_writedata} = 64'h0;
    seed = 85;
    cyc(5);
    i_rst_b <= 1'b1;
    rd(OFS_FIFO_STATUS, 32'h2, 32'h2, "tx_not_full_flag");
    rd(OFS_TX_FILL_LEVEL, 32'h0, 32'hffffffff, "tx level");
    rd(OFS_RX_FILL_LEVEL, 32'h0, 32'hffffffff, "rx level");
    rd(OFS_SW_RESET_CTRL, 32'h0, 32'hffffffff, "software reset");
    rd(32'h50001000, 32'h0, 32'hffffffff, "unmapped");
    // one push beyond depth must be dropped
    strobe(DEPTH + 1, 1'b1, 1'b0, 1'b0);
    rd(OFS_TX_FILL_LEVEL, DEPTH, 32'hffffffff, "tx level full");
    rd(OFS_FIFO_STATUS, 32'h0, 32'h2, "tx_not_full_flag full");
    rd(OFS_IRQ_STATUS, 32'h5, 32'h7, "irq status");
    wr(OFS_IRQ_MASK, 32'h1);
    cyc(1);
    chk("irq raised", 32'h1, o_irq);
    wr(OFS_IRQ_STATUS, 32'h1);
    cyc(1);
    chk("irq cleared", 32'h0, o_irq);
    wr(OFS_IRQ_MASK, 32'h0);
    strobe(1, 1'b1, 1'b0, 1'b1);
    rd(OFS_FIFO_STATUS, 32'h2, 32'h2, "tx_not_full_flag room");
    n = ($random(seed) & 3) + 1;
    strobe(n, 1'b0, 1'b1, 1'b0);
    rd(OFS_RX_FILL_LEVEL, n, 32'hffffffff, "rx level random");
    wr(OFS_SW_RESET_CTRL, 32'h0);
    bus(1'b1, OFS_SW_RESET_CTRL, 32'h6, 4'he);
    rd(OFS_RX_FILL_LEVEL, n, 32'hffffffff, "rx level kept");
    rd(OFS_TX_FILL_LEVEL, DEPTH - 1, 32'hffffffff, "tx level kept");
    wr(OFS_SW_RESET_CTRL, 32'h2);
    rd(OFS_RX_FILL_LEVEL, 32'h0, 32'hffffffff, "rx queue reset");
    rd(OFS_TX_FILL_LEVEL, DEPTH - 1, 32'hffffffff, "tx level untouched");
    wr(OFS_SW_RESET_CTRL, 32'h4);
    rd(OFS_TX_FILL_LEVEL, 32'h0, 32'hffffffff, "tx queue reset");
    rd(OFS_SW_RESET_CTRL, 32'h0, 32'hffffffff, "self clear");
    // request-to-send through the shadow, flow control and loopback
    wd = $random(seed);
    wr(OFS_RTS_SHADOW, wd | 32'h1);
    cyc(2);
    chk("rts_b low", 32'h0, o_rts_b);
    chk("partner may send", 32'h1, may_send);
    rd(OFS_RTS_SHADOW, 32'h1, 32'h1, "rts shadow");
    chk("rts ctrl", 32'h1, o_rts_ctrl);
    {i_auto_flow_en, i_queue_en, i_rx_above_trigger} <= 3'h7;
    cyc(3);
    chk("rts_b above trigger", 32'h1, o_rts_b);
    i_queue_en <= 1'b0;
    cyc(3);
    chk("rts_b queues off", 32'h0, o_rts_b);
    i_loopback_en <= 1'b1;
    cyc(3);
    chk("rts_b loopback", 32'h1, o_rts_b);
    chk("loop cts", 32'h1, o_loop_cts);
    {i_modem_rts_wr, i_modem_rts_wdata} <= 2'h2;
    cyc(1);
    i_modem_rts_wr <= 1'b0;
    rd(OFS_RTS_SHADOW, 32'h0, 32'h1, "rts shared storage");
    chk("loop cts cleared", 32'h0, o_loop_cts);
    {i_loopback_en, i_auto_flow_en, i_rx_above_trigger} <= 3'h0;
    // break on the line, infrared and loopback
    wr(OFS_BREAK_SHADOW, 32'h1);
    cyc(2);
    chk("break ctrl", 32'h1, o_break_ctrl);
    cyc(16);
    chk("sout held low", 32'h0, o_sout);
    chk("partner break", 32'h1, break_seen);
    i_ir_mode_en <= 1'b1;
    cyc(3);
    ir_prev = o_ir_out_b;
    cyc(1);
    chk("ir pulse", {31'h0, ~ir_prev}, o_ir_out_b);
    {i_ir_mode_en, i_loopback_en} <= 2'h1;
    cyc(3);
    chk("sout loopback", 32'h1, o_sout);
    chk("loop rx break", 32'h0, o_loop_rx);
    {i_line_break_wr, i_line_break_wdata, i_loopback_en} <= 3'h4;
    cyc(1);
    i_line_break_wr <= 1'b0;
    rd(OFS_BREAK_SHADOW, 32'h0, 32'h1, "break shared storage");
    cyc(3);
    chk("sout released", 32'h1, o_sout);
    // whole controller reset clears levels and shared bits
    strobe(1, 1'b0, 1'b1, 1'b0);
    wr(OFS_RTS_SHADOW, 32'h1);
    wr(OFS_SW_RESET_CTRL, 32'h1);
    saw_low = 1'b0;
    repeat (6) begin
      @(posedge i_clk);
      saw_low = saw_low | (o_ctrl_rst_b === 1'b0);
    end
    chk("controller reset pulse", 32'h1, saw_low);
    chk("controller reset released", 32'h1, o_ctrl_rst_b);
    rd(OFS_RX_FILL_LEVEL, 32'h0, 32'hffffffff, "rx level after reset");
    rd(OFS_RTS_SHADOW, 32'h0, 32'h1, "rts after reset");
    cyc(2);
    end_of_test;
  end
endmodule : test_uart_shadow_status_regs

`default_nettype wire
